/* File: ldks_pkg.sv */
// constants, register map and types of the led display and keypad scanner
package ldks_pkg;

    // clock and scan timing
    localparam int unsigned CLK_FREQ_HZ      = 25_000_000;
    localparam int unsigned CLK_FREQ_MHZ     = 25;
    localparam int unsigned SCAN_FREQ_HZ     = 640;
    localparam int unsigned REFRESH_PERIOD_US = 1560;
    // one latch phase is half a scan clock period, rounded down
    localparam int unsigned PHASE_CYCLES     = CLK_FREQ_HZ / (2 * SCAN_FREQ_HZ);
    // refresh of both latches, compared against the 1.56 ms figure
    localparam int unsigned REFRESH_CYCLES   = 2 * PHASE_CYCLES;
    localparam int unsigned REFRESH_MAX_CYCLES = REFRESH_PERIOD_US * CLK_FREQ_MHZ + CLK_FREQ_MHZ;
    // anti-ghost blanking, a least time rounded up
    localparam int unsigned BLANK_NS         = 1000;
    localparam int unsigned BLANK_CYCLES     = (BLANK_NS * CLK_FREQ_MHZ + 999) / 1000;

    // widths
    localparam int unsigned SEL_W            = 3;
    localparam int unsigned SEG_W            = 8;
    localparam int unsigned COL_W            = 3;
    localparam int unsigned LINES            = 8;

    // register byte addresses
    localparam logic [7:0] ADDR_LATCH_A      = 8'h00;
    localparam logic [7:0] ADDR_LATCH_B      = 8'h04;
    localparam logic [7:0] ADDR_SELECT       = 8'h08;
    localparam logic [7:0] ADDR_STATUS       = 8'h0C;

    // status field positions
    localparam int unsigned ST_COLUMN_LSB    = 0;
    localparam int unsigned ST_PHASE_BIT     = 3;
    localparam int unsigned ST_REQUEST_BIT   = 4;
    localparam int unsigned ST_BLANK_BIT     = 5;
    // select register: display enable bit above the select code
    localparam int unsigned SEL_ENABLE_BIT   = 3;

    // reset values
    localparam logic [7:0] SEG_RESET         = 8'h00;
    localparam logic [2:0] SEL_RESET         = 3'h0;
    localparam logic       ENABLE_RESET      = 1'b0;

    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ     = 2'h2;
    localparam logic       HRESP_OKAY        = 1'b0;

    typedef enum logic [3:0] {
        LDKS_BLANK_A = 4'h1,
        LDKS_SHOW_A  = 4'h2,
        LDKS_BLANK_B = 4'h4,
        LDKS_SHOW_B  = 4'h8
    } ldks_state_t;

endpackage

/* File: ldks_scanner.sv */
// multiplexed led display and key-matrix scanner with an ahb-lite register port
//
// Implementation choices: the AHB-Lite slave port and the address map.
module ldks_scanner #(
    parameter int unsigned PHASE_CYCLES = ldks_pkg::PHASE_CYCLES,
    parameter int unsigned BLANK_CYCLES = ldks_pkg::BLANK_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    // display and keypad pins
    output logic [7:0]       segment_o,
    output logic             segment_latch_a_en_o,
    output logic             segment_latch_b_en_o,
    output logic [7:0]       digit_select_n_o,
    output logic [7:0]       row_drive_o,
    input  wire logic [2:0]  column_sense_i,
    output logic             scan_request_o
);

    // refused at elaboration: a short phase leaves no lit time after blanking
    if (PHASE_CYCLES < 2 * BLANK_CYCLES + 2 || BLANK_CYCLES < 1) begin : g_bad_timing
        $error("ldks_scanner: phase must exceed twice the blanking time");
    end

    localparam int unsigned CNT_W = $clog2(PHASE_CYCLES + 1);

    // decoder used by both the digit and the row side
    function automatic logic [7:0] decode_line(input logic [2:0] code);
        logic [7:0] onehot;
        onehot = 8'h00;
        onehot[code] = 1'b1;
        return onehot;
    endfunction

    // ---------------- ahb-lite slave ----------------
    logic [7:0]  seg_a_reg;
    logic [7:0]  seg_b_reg;
    logic [2:0]  select_reg;
    logic        disp_en_reg;
    logic        request_reg;
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic [2:0]  col_meta_reg;
    logic [2:0]  col_sync_reg;
    // one-hot: bits 2 and 3 mean latch b, bits 0 and 2 mean blanking
    ldks_pkg::ldks_state_t state_reg;
    logic        data_change;

    wire logic addr_take = hsel_i && hready_i && htrans_i == ldks_pkg::HTRANS_NONSEQ;
    // write strobes live in the data phase, one cycle after the address
    wire logic wr_a      = wr_pend_reg && wr_addr_reg == ldks_pkg::ADDR_LATCH_A;
    wire logic wr_b      = wr_pend_reg && wr_addr_reg == ldks_pkg::ADDR_LATCH_B;
    wire logic wr_sel    = wr_pend_reg && wr_addr_reg == ldks_pkg::ADDR_SELECT;

    // zero wait states: ready only drops while reset holds
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hreadyout_o <= 1'b0;
            hresp_o     <= ldks_pkg::HRESP_OKAY;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= ldks_pkg::HRESP_OKAY;
        end
    end

    // write data arrives in the data phase, so the address is held one cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_take && hwrite_i;
            if (addr_take) begin
                wr_addr_reg <= haddr_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            seg_a_reg   <= ldks_pkg::SEG_RESET;
            seg_b_reg   <= ldks_pkg::SEG_RESET;
            select_reg  <= ldks_pkg::SEL_RESET;
            disp_en_reg <= ldks_pkg::ENABLE_RESET;
        end else begin
            if (wr_a) begin
                seg_a_reg <= hwdata_i[7:0];
            end
            if (wr_b) begin
                seg_b_reg <= hwdata_i[7:0];
            end
            if (wr_sel) begin
                select_reg  <= hwdata_i[2:0];
                disp_en_reg <= hwdata_i[ldks_pkg::SEL_ENABLE_BIT];
            end
        end
    end

    // read data is captured at the address phase, no wait states
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (addr_take && !hwrite_i) begin
            hrdata_reg <= 32'h0000_0000;
            case (haddr_i[7:0])
                ldks_pkg::ADDR_LATCH_A: hrdata_reg[7:0] <= seg_a_reg;
                ldks_pkg::ADDR_LATCH_B: hrdata_reg[7:0] <= seg_b_reg;
                ldks_pkg::ADDR_SELECT: begin
                    hrdata_reg[2:0] <= select_reg;
                    hrdata_reg[ldks_pkg::SEL_ENABLE_BIT] <= disp_en_reg;
                end
                ldks_pkg::ADDR_STATUS: begin
                    hrdata_reg[ldks_pkg::ST_COLUMN_LSB +: 3] <= col_sync_reg;
                    hrdata_reg[ldks_pkg::ST_PHASE_BIT] <= state_reg[2] | state_reg[3];
                    hrdata_reg[ldks_pkg::ST_REQUEST_BIT] <= request_reg;
                    hrdata_reg[ldks_pkg::ST_BLANK_BIT] <= state_reg[0] | state_reg[2];
                end
                default: hrdata_reg <= 32'h0000_0000;
            endcase
        end
    end
    assign hrdata_o = hrdata_reg;

    // ---------------- column sense ----------------
    // pins are asynchronous: two stages before any use
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            col_meta_reg <= 3'h0;
            col_sync_reg <= 3'h0;
        end else begin
            col_meta_reg <= column_sense_i;
            col_sync_reg <= col_meta_reg;
        end
    end

    // ---------------- scan timing ----------------
    logic [CNT_W-1:0] phase_cnt_reg;
    logic [CNT_W-1:0] blank_cnt_reg;
    logic             phase_tick;

    // each tick ends one half of the 640 Hz scan clock
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_cnt_reg <= '0;
        end else if (phase_tick) begin
            phase_cnt_reg <= '0;
        end else begin
            phase_cnt_reg <= phase_cnt_reg + CNT_W'(1);
        end
    end
    assign phase_tick = phase_cnt_reg == CNT_W'(PHASE_CYCLES - 1);

    // any write to displayed data restarts the blanking window
    assign data_change = wr_a || wr_b || wr_sel;

    // a write restarts the count, so a burst of writes keeps the display dark
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg     <= ldks_pkg::LDKS_BLANK_A;
            blank_cnt_reg <= '0;
        end else begin
            case (state_reg)
                ldks_pkg::LDKS_BLANK_A: begin
                    if (phase_tick) begin
                        state_reg     <= ldks_pkg::LDKS_BLANK_B;
                        blank_cnt_reg <= '0;
                    end else if (data_change) begin
                        blank_cnt_reg <= '0;
                    end else if (blank_cnt_reg == CNT_W'(BLANK_CYCLES - 1)) begin
                        state_reg <= ldks_pkg::LDKS_SHOW_A;
                    end else begin
                        blank_cnt_reg <= blank_cnt_reg + CNT_W'(1);
                    end
                end
                ldks_pkg::LDKS_SHOW_A: begin
                    blank_cnt_reg <= '0;
                    if (phase_tick) begin
                        state_reg <= ldks_pkg::LDKS_BLANK_B;
                    end else if (data_change) begin
                        state_reg <= ldks_pkg::LDKS_BLANK_A;
                    end
                end
                ldks_pkg::LDKS_BLANK_B: begin
                    if (phase_tick) begin
                        state_reg     <= ldks_pkg::LDKS_BLANK_A;
                        blank_cnt_reg <= '0;
                    end else if (data_change) begin
                        blank_cnt_reg <= '0;
                    end else if (blank_cnt_reg == CNT_W'(BLANK_CYCLES - 1)) begin
                        state_reg <= ldks_pkg::LDKS_SHOW_B;
                    end else begin
                        blank_cnt_reg <= blank_cnt_reg + CNT_W'(1);
                    end
                end
                ldks_pkg::LDKS_SHOW_B: begin
                    blank_cnt_reg <= '0;
                    if (phase_tick) begin
                        state_reg <= ldks_pkg::LDKS_BLANK_A;
                    end else if (data_change) begin
                        state_reg <= ldks_pkg::LDKS_BLANK_B;
                    end
                end
                default: begin
                    state_reg     <= ldks_pkg::LDKS_BLANK_A;
                    blank_cnt_reg <= '0;
                end
            endcase
        end
    end

    // ---------------- scan request ----------------
    // raised as latch b's phase ends; a latch b write clears it, but a
    // new raise in that same cycle wins
    wire logic pair_done = phase_tick && (state_reg == ldks_pkg::LDKS_BLANK_B ||
                                          state_reg == ldks_pkg::LDKS_SHOW_B);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            request_reg <= 1'b0;
        end else if (pair_done) begin
            request_reg <= 1'b1;
        end else if (wr_b) begin
            request_reg <= 1'b0;
        end
    end
    assign scan_request_o = request_reg;

    // ---------------- pin drivers ----------------
    logic show_a;
    logic show_b;
    assign show_a = disp_en_reg && state_reg == ldks_pkg::LDKS_SHOW_A && !data_change;
    assign show_b = disp_en_reg && state_reg == ldks_pkg::LDKS_SHOW_B && !data_change;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            segment_latch_a_en_o <= 1'b0;
            segment_latch_b_en_o <= 1'b0;
        end else begin
            segment_latch_a_en_o <= show_a && !phase_tick;
            segment_latch_b_en_o <= show_b && !phase_tick;
        end
    end

    // segments only pass while a latch is enabled
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            segment_o <= 8'h00;
        end else if (show_a && !phase_tick) begin
            segment_o <= seg_a_reg;
        end else if (show_b && !phase_tick) begin
            segment_o <= seg_b_reg;
        end else begin
            segment_o <= 8'h00;
        end
    end

    // digit lines: one low output, line 2 (code 010) is the first digit;
    // annunciator groups sit on the same lines
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            digit_select_n_o <= 8'hFF;
        end else if ((show_a || show_b) && !phase_tick) begin
            digit_select_n_o <= ~decode_line(select_reg);
        end else begin
            digit_select_n_o <= 8'hFF;
        end
    end

    // keypad rows are not blanked so columns settle for the processor read
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            row_drive_o <= 8'h00;
        end else begin
            row_drive_o <= decode_line(select_reg);
        end
    end

endmodule

/* File: ldks_scanner_assertions.sv */
// port checker of the led display and keypad scanner
module ldks_scanner_assertions #(
    parameter int unsigned PHASE_CYCLES = 60
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       hresp_o,
    input  wire logic       hreadyout_o,
    input  wire logic [7:0] segment_o,
    input  wire logic       segment_latch_a_en_o,
    input  wire logic       segment_latch_b_en_o,
    input  wire logic [7:0] digit_select_n_o,
    input  wire logic [7:0] row_drive_o,
    input  wire logic       scan_request_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int REF = 2 * PHASE_CYCLES;
    logic        on;
    int unsigned len_q;
    int unsigned req_q;
    logic        seen_q;
    logic        req_prev_q;
    assign on = segment_latch_a_en_o | segment_latch_b_en_o;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            len_q <= 0;
        end else begin
            len_q <= on ? len_q + 1 : 0;
        end
    end
    // requests sit on the phase grid, so rises are whole refreshes apart
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_q      <= 0;
            seen_q     <= 1'b0;
            req_prev_q <= 1'b0;
        end else begin
            req_q      <= (scan_request_o && !req_prev_q) ? 0 : req_q + 1;
            seen_q     <= seen_q | (scan_request_o && !req_prev_q);
            req_prev_q <= scan_request_o;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_dark;
        !segment_latch_a_en_o && !segment_latch_b_en_o;
    endsequence
    property p_excl;
        !(segment_latch_a_en_o && segment_latch_b_en_o);
    endproperty
    a_excl: assert property (p_excl) else $error("both latch enables high");
    property p_gap;
        $fell(segment_latch_a_en_o) || $fell(segment_latch_b_en_o) |-> s_dark [*3];
    endproperty
    a_gap: assert property (p_gap) else $error("no blank gap after phase");
    property p_hold;
        (segment_latch_a_en_o && $past(segment_latch_a_en_o))
            || (segment_latch_b_en_o && $past(segment_latch_b_en_o))
            |-> $stable(segment_o) && $stable(digit_select_n_o);
    endproperty
    a_hold: assert property (p_hold) else $error("display changed while lit");
    property p_dig;
        on |-> $onehot(~digit_select_n_o);
    endproperty
    a_dig: assert property (p_dig) else $error("digit select not one low");
    property p_dark;
        !on |-> digit_select_n_o == 8'hFF && segment_o == 8'h00;
    endproperty
    a_dark: assert property (p_dark) else $error("segments lit while disabled");
    property p_same;
        on |-> ~digit_select_n_o == row_drive_o;
    endproperty
    a_same: assert property (p_same) else $error("digit and row decode differ");
    property p_rows;
        hreadyout_o |-> $onehot(row_drive_o);
    endproperty
    a_rows: assert property (p_rows) else $error("row drive not one-hot");
    property p_len;
        len_q < PHASE_CYCLES;
    endproperty
    a_len: assert property (p_len) else $error("latch shown beyond a phase");
    property p_req;
        $rose(scan_request_o) && seen_q |-> (req_q % REF) == REF - 1;
    endproperty
    a_req: assert property (p_req) else $error("scan request off refresh grid");
    property p_okay;
        hresp_o == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("bus response not okay");
endmodule

/* File: ldks_keypad_model.sv */
// switch matrix model: closed switches tie the driven row onto their column
module ldks_keypad_model (
    input  wire logic [7:0]  row_i,
    input  wire logic [23:0] closed_i,
    output logic      [2:0]  column_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // open columns fall low through their pull-downs
    always_comb begin
        column_o = 3'h0;
        for (int r = 0; r < 8; r++) begin
            if (row_i[r]) begin
                column_o = column_o | closed_i[r*3 +: 3];
            end
        end
    end
endmodule

/* File: tb_top.sv */
// self-checking testbench of the led display and keypad scanner
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PH = 60;
    logic        clk_i = 1'b0;
    logic        rst_i;
    logic        hsel_i;
    logic [31:0] haddr_i;
    logic [1:0]  htrans_i;
    logic        hwrite_i;
    logic [2:0]  hsize_i;
    logic [31:0] hwdata_i;
    logic        hreadyout_o;
    logic        hresp_o;
    logic [31:0] hrdata_o;
    logic [7:0]  segment_o;
    logic        en_a;
    logic        en_b;
    logic [7:0]  digit_select_n_o;
    logic [7:0]  row_drive_o;
    logic [2:0]  column_sense_i;
    logic        scan_request_o;
    logic [23:0] closed;
    logic [31:0] q;
    logic [31:0] pa;
    logic [31:0] pb;
    time         t0;
    int          n_fail = 0;
    int          compares = 0;
    int          seed = 39017;
    ldks_scanner #(.PHASE_CYCLES(PH), .BLANK_CYCLES(4)) ldks_scanner_inst (
        .clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
        .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o, .segment_o,
        .segment_latch_a_en_o(en_a), .segment_latch_b_en_o(en_b), .digit_select_n_o,
        .row_drive_o, .column_sense_i, .scan_request_o);
    ldks_keypad_model ldks_keypad_model_inst (
        .row_i(row_drive_o), .closed_i(closed), .column_o(column_sense_i));
    always #20 clk_i = ~clk_i;
    task finish_test;
        if (n_fail == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // waits sample just after the edge so registered outputs have settled
    task wlvl(input int s, input logic v);
        int   n;
        logic x;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
            x = (s == 0) ? en_a : (s == 1) ? en_b : (s == 2) ? scan_request_o : hreadyout_o;
        end while (x !== v && n < 1000);
        if (n >= 1000) begin
            n_fail++;
            finish_test;
        end
    endtask
    // bus waits read hready at the edge itself, before the slave updates it
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 1000);
        if (hreadyout_o !== 1'b1) begin
            n_fail++;
            finish_test;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        hsel_i   <= 1'b1;
        haddr_i  <= {24'h0, a};
        hwrite_i <= w;
        htrans_i <= ldks_pkg::HTRANS_NONSEQ;
        wait_ready;
        htrans_i <= 2'h0;
        hsel_i   <= 1'b0;
        hwdata_i <= d;
        wait_ready;
        q = hrdata_o;
    endtask
    function automatic logic [2:0] cols(input logic [23:0] m, input logic [2:0] c);
        return m[c*3 +: 3];
    endfunction
    initial begin
        {hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i, closed} = '0;
        hsize_i = 3'h2;
        rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, ldks_pkg::ADDR_LATCH_A, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0);
        for (int c = 0; c < 8; c++) begin
            @(posedge clk_i);
            closed <= 24'($random(seed));
            bus(1'b1, ldks_pkg::ADDR_SELECT, 32'(c));
            repeat (4) @(posedge clk_i);
            chk(32'(row_drive_o), 32'h1 << c);
            bus(1'b0, ldks_pkg::ADDR_STATUS, 32'h0);
            chk(32'(q[2:0]), 32'(cols(closed, 3'(c))));
        end
        pa = $random(seed);
        pb = $random(seed);
        bus(1'b1, ldks_pkg::ADDR_LATCH_A, pa);
        bus(1'b1, ldks_pkg::ADDR_LATCH_B, pb);
        bus(1'b1, ldks_pkg::ADDR_SELECT, 32'h0A);
        bus(1'b0, ldks_pkg::ADDR_LATCH_B, 32'h0);
        chk(q, 32'(pb[7:0]));
        bus(1'b0, ldks_pkg::ADDR_SELECT, 32'h0);
        chk(q, 32'h0A);
        wlvl(0, 1'b1);
        chk(32'(segment_o), 32'(pa[7:0]));
        chk(32'(digit_select_n_o), 32'hFB);
        wlvl(1, 1'b1);
        chk(32'(segment_o), 32'(pb[7:0]));
        chk(32'(digit_select_n_o), 32'hFB);
        bus(1'b0, ldks_pkg::ADDR_STATUS, 32'h0);
        chk(32'({q[ldks_pkg::ST_BLANK_BIT], q[ldks_pkg::ST_PHASE_BIT]}), 32'h1);
        wlvl(0, 1'b1);
        t0 = $time;
        wlvl(0, 1'b0);
        wlvl(0, 1'b1);
        chk(32'(($time - t0) / 40), 32'(2 * PH));
        wlvl(2, 1'b1);
        bus(1'b0, ldks_pkg::ADDR_STATUS, 32'h0);
        chk(32'(q[ldks_pkg::ST_REQUEST_BIT]), 32'h1);
        bus(1'b1, ldks_pkg::ADDR_LATCH_B, pb);
        bus(1'b0, ldks_pkg::ADDR_STATUS, 32'h0);
        chk(32'(q[ldks_pkg::ST_REQUEST_BIT]), 32'h0);
        // random writes in mid-phase, status included as a read-only target
        repeat (40) begin
            bus(1'b1, 8'(($random(seed) & 3) << 2), 32'h8 | ($random(seed) & 32'hF7));
            repeat ($unsigned($random(seed)) % 30) @(posedge clk_i);
        end
        repeat (3 * PH) @(posedge clk_i);
        finish_test;
    end
endmodule
bind ldks_scanner ldks_scanner_assertions #(.PHASE_CYCLES(PHASE_CYCLES))
    ldks_scanner_assertions_inst (
    .clk_i(clk_i), .rst_i(rst_i), .hresp_o(hresp_o), .hreadyout_o(hreadyout_o),
    .segment_o(segment_o), .segment_latch_a_en_o(segment_latch_a_en_o),
    .segment_latch_b_en_o(segment_latch_b_en_o), .digit_select_n_o(digit_select_n_o),
    .row_drive_o(row_drive_o), .scan_request_o(scan_request_o));
